/* File: hw/scr_regs.sv */
// Serial-port register bank: interface, power state, identity, level
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Writing one to interface bit 7 resets all registers; bit clears itself.
// [R2] Streaming steps address up when direction bit is one, down when zero.
// [R3] Write to address zero lands only if low nibble mirrors high nibble.
// [R4] Host writes reserved fields with their required values.
// [R5] Power field: 00 normal, 10 sleep, 11 power-down, 01 reserved.
// [R6] Leaving a power-down state for normal starts converter calibration.
// [R7] Part class low nibble is read-only fixed converter class code.
// [R8] Read-only 16-bit part identifier at 0x4/0x5, revision at 0x6.
// [R9] Read-only 16-bit maker identifier at 0xC/0xD.
// [R10] Level field: 00 1.2V, 01 3.3V, 10 2.5V, 11 1.8V.
// [R11] Host sets the level field before issuing any read.
module scr_regs #(
  parameter logic [3:0]  PART_CLASS_CODE = 4'h5,     // Arbitrary value
  parameter logic [15:0] PART_IDENT_CODE = 16'hA5C3, // Arbitrary value
  parameter logic [7:0]  PART_REV_CODE   = 8'h1B,    // Arbitrary value
  parameter logic [15:0] MAKER_CODE      = 16'h7E29  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Serial port pins
  input  wire scr_pkg::scr_spi_in_s spi_i,
  output var  scr_pkg::scr_spi_out_s spi_o,
  // Control to the converter
  output var  scr_pkg::scr_ctrl_s   ctrl_o,
  output logic                      calib_start_o
);
  import scr_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  scr_state_e        state_r;
  logic              sclk_q_r;
  logic              sclk_rise;
  logic              sclk_fall;
  logic [3:0]        bit_cnt_r;
  logic [CMD_BITS-1:0] shift_r;
  logic [CMD_BITS-1:0] shift_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic              read_r;
  logic [7:0]        rd_byte_r;
  logic [7:0]        rd_data;
  logic [7:0]        next_rd_data;
  logic [ADDR_W-1:0] step_addr;
  logic              sdo_r;
  logic              wr_stb;
  logic              soft_rst;
  logic              mirror_ok;
  logic [3:0]        mirror_bit;
  logic [7:0]        iface_cfg_r;
  logic [7:0]        pwr_cfg_r;
  logic [7:0]        lvl_cfg_r;
  logic [1:0]        pwr_prev_r;
  logic              calib_r;

  // ****************************************************************
  // Serial clock edge detection
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= spi_i.sclk;
    end
  end

  assign sclk_rise = spi_i.sclk & ~sclk_q_r & ~spi_i.cs_n;
  assign sclk_fall = ~spi_i.sclk & sclk_q_r & ~spi_i.cs_n;
  assign shift_nxt = {shift_r[CMD_BITS-2:0], spi_i.sdi};

  // Next address in a stream
  assign step_addr = iface_cfg_r[STREAM_DIRECTION_BIT]
                   ? addr_r + 15'h0001                    // [R2]
                   : addr_r - 15'h0001;                   // [R2]

  // Write lands on the eighth data bit of a write frame
  assign wr_stb = sclk_rise && (state_r == ST_DATA) && !read_r
               && (bit_cnt_r == DATA_LAST);

  // Mirror check: each low bit must equal its partner in the high nibble
  for (genvar b = 0; b < 4; b++) begin : g_mirror
    assign mirror_bit[b] = (shift_nxt[b] == shift_nxt[7-b]); // [R3]
  end
  assign mirror_ok = &mirror_bit;                         // [R3]

  assign soft_rst = wr_stb && (addr_r == OFS_INTERFACE_CONFIG) && mirror_ok
                 && shift_nxt[SELF_CLEARING_RESET_BIT];   // [R1]

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a,
                                          input logic [7:0] ic,
                                          input logic [7:0] pc,
                                          input logic [7:0] lc);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      OFS_INTERFACE_CONFIG:    d = ic;
      OFS_POWER_STATE_CONFIG:  d = pc;
      OFS_PART_CLASS:          d = {4'h0, PART_CLASS_CODE};  // [R7]
      OFS_PART_IDENT_LOW:      d = PART_IDENT_CODE[7:0];     // [R8]
      OFS_PART_IDENT_HIGH:     d = PART_IDENT_CODE[15:8];    // [R8]
      OFS_PART_REVISION:       d = PART_REV_CODE;            // [R8]
      OFS_MAKER_IDENT_LOW:     d = MAKER_CODE[7:0];          // [R9]
      OFS_MAKER_IDENT_HIGH:    d = MAKER_CODE[15:8];         // [R9]
      OFS_SERIAL_LEVEL_CONFIG: d = lc;
      default:                 d = 8'h00;
    endcase
    return d;
  endfunction : read_mux

  assign rd_data      = read_mux(shift_nxt[ADDR_W-1:0], iface_cfg_r,
                                 pwr_cfg_r, lvl_cfg_r);
  assign next_rd_data = read_mux(step_addr, iface_cfg_r,
                                 pwr_cfg_r, lvl_cfg_r);

  // ****************************************************************
  // Frame sequencer: command then streamed data bytes
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r   <= ST_CMD;
      bit_cnt_r <= 4'h0;
      shift_r   <= 16'h0000;
      addr_r    <= 15'h0000;
      read_r    <= 1'b0;
      rd_byte_r <= 8'h00;
    end else if (spi_i.cs_n) begin
      state_r   <= ST_CMD;
      bit_cnt_r <= 4'h0;
    end else if (sclk_rise) begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_cnt_r + 4'h1;
      unique case (state_r)
        ST_CMD: begin
          if (bit_cnt_r == CMD_LAST) begin
            state_r   <= ST_DATA;
            bit_cnt_r <= 4'h0;
            read_r    <= shift_nxt[RW_POS];
            addr_r    <= shift_nxt[ADDR_W-1:0];
            rd_byte_r <= rd_data;
          end
        end
        ST_DATA: begin
          if (bit_cnt_r == DATA_LAST) begin
            bit_cnt_r <= 4'h0;
            addr_r    <= step_addr;                       // [R2]
            rd_byte_r <= next_rd_data;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Serial output: changes on falling clock, sampled on rising
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_r <= 1'b0;
    end else if (spi_i.cs_n) begin
      sdo_r <= 1'b0;
    end else if (sclk_fall && state_r == ST_DATA && read_r) begin
      sdo_r <= rd_byte_r[3'(DATA_LAST - bit_cnt_r)];
    end
  end

  // Drive only during the data phase of a read frame
  assign spi_o.sdo    = sdo_r;
  assign spi_o.sdo_oe = ~spi_i.cs_n && (state_r == ST_DATA) && read_r;

  // ****************************************************************
  // Interface configuration register
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      iface_cfg_r <= RST_INTERFACE_CONFIG;
    end else if (soft_rst) begin
      iface_cfg_r <= RST_INTERFACE_CONFIG;                // [R1]
    end else if (wr_stb && addr_r == OFS_INTERFACE_CONFIG && mirror_ok) begin
      iface_cfg_r <= shift_nxt[7:0];                      // [R3]
      iface_cfg_r[FIXED_ONE_BIT] <= 1'b1;                 // Read-only one
    end
  end

  // ****************************************************************
  // Power state and level registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_cfg_r <= RST_POWER_STATE_CONFIG;
    end else if (soft_rst) begin
      pwr_cfg_r <= RST_POWER_STATE_CONFIG;                // [R1]
    end else if (wr_stb && addr_r == OFS_POWER_STATE_CONFIG) begin
      pwr_cfg_r <= shift_nxt[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_cfg_r <= RST_SERIAL_LEVEL_CONFIG;
    end else if (soft_rst) begin
      lvl_cfg_r <= RST_SERIAL_LEVEL_CONFIG;               // [R1]
    end else if (wr_stb && addr_r == OFS_SERIAL_LEVEL_CONFIG) begin
      lvl_cfg_r <= shift_nxt[7:0];                        // [R10]
    end
  end

  // ****************************************************************
  // Calibration on return from sleep or power-down
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_prev_r <= PWR_NORMAL;
      calib_r    <= 1'b0;
    end else begin
      pwr_prev_r <= pwr_cfg_r[1:0];
      calib_r    <= (pwr_prev_r == PWR_SLEEP || pwr_prev_r == PWR_DOWN)
                 && (pwr_cfg_r[1:0] == PWR_NORMAL);        // [R6]
    end
  end

  assign calib_start_o = calib_r;

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  assign ctrl_o.power_state_field  = pwr_cfg_r[1:0];
  assign ctrl_o.sleep              = (pwr_cfg_r[1:0] == PWR_SLEEP); // [R5]
  assign ctrl_o.power_down         = (pwr_cfg_r[1:0] == PWR_DOWN);  // [R5]
  assign ctrl_o.serial_level_field = lvl_cfg_r[1:0];                // [R10]

endmodule : scr_regs
`default_nettype wire

/* File: hw/scr_pkg.sv */
// Shared constants and types for the serial configuration register bank
package scr_pkg;

  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned CMD_BITS   = 16;
  localparam int unsigned DATA_BITS  = 8;
  localparam logic [3:0]  CMD_LAST   = 4'hF;
  localparam logic [3:0]  DATA_LAST  = 4'h7;
  localparam int unsigned RW_POS     = 15;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_INTERFACE_CONFIG    = 15'h0000;
  localparam logic [ADDR_W-1:0] OFS_POWER_STATE_CONFIG  = 15'h0002;
  localparam logic [ADDR_W-1:0] OFS_PART_CLASS          = 15'h0003;
  localparam logic [ADDR_W-1:0] OFS_PART_IDENT_LOW      = 15'h0004;
  localparam logic [ADDR_W-1:0] OFS_PART_IDENT_HIGH     = 15'h0005;
  localparam logic [ADDR_W-1:0] OFS_PART_REVISION       = 15'h0006;
  localparam logic [ADDR_W-1:0] OFS_MAKER_IDENT_LOW     = 15'h000C;
  localparam logic [ADDR_W-1:0] OFS_MAKER_IDENT_HIGH    = 15'h000D;
  localparam logic [ADDR_W-1:0] OFS_SERIAL_LEVEL_CONFIG = 15'h0010;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] RST_INTERFACE_CONFIG    = 8'h3C;
  localparam logic [7:0] RST_POWER_STATE_CONFIG  = 8'h00;
  localparam logic [7:0] RST_SERIAL_LEVEL_CONFIG = 8'h01;
  localparam int unsigned SELF_CLEARING_RESET_BIT = 7;
  localparam int unsigned STREAM_DIRECTION_BIT    = 5;
  localparam int unsigned FIXED_ONE_BIT           = 4;

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  localparam logic [1:0] PWR_NORMAL   = 2'h0;
  localparam logic [1:0] PWR_RESERVED = 2'h1;
  localparam logic [1:0] PWR_SLEEP    = 2'h2;
  localparam logic [1:0] PWR_DOWN     = 2'h3;

  localparam logic [1:0] LVL_1V2 = 2'h0;
  localparam logic [1:0] LVL_3V3 = 2'h1;
  localparam logic [1:0] LVL_2V5 = 2'h2;
  localparam logic [1:0] LVL_1V8 = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_CMD  = 2'b01,
    ST_DATA = 2'b10
  } scr_state_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } scr_spi_in_s;

  typedef struct packed {
    logic sdo;
    logic sdo_oe;
  } scr_spi_out_s;

  typedef struct packed {
    logic [1:0] power_state_field;
    logic       sleep;
    logic       power_down;
    logic [1:0] serial_level_field;
  } scr_ctrl_s;

endpackage : scr_pkg

/* File: bench/scr_regs_properties.sv */
// Port checker for the serial configuration register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_properties (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // Watched ports
  input wire scr_pkg::scr_spi_in_s  spi_i,
  input wire scr_pkg::scr_spi_out_s spi_o,
  input wire scr_pkg::scr_ctrl_s    ctrl_o,
  input wire logic                  calib_start_o
);
  import scr_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Low-power state of either kind
  wire logic asleep = ctrl_o.sleep | ctrl_o.power_down;
  sleep_decode_a: assert property (
    ctrl_o.sleep == (ctrl_o.power_state_field == PWR_SLEEP))
    else $error("sleep flag disagrees with power field");
  down_decode_a: assert property (
    ctrl_o.power_down == (ctrl_o.power_state_field == PWR_DOWN))
    else $error("power-down flag disagrees with power field");
  calib_on_exit_a: assert property (
    $fell(asleep) && ctrl_o.power_state_field == PWR_NORMAL
    |-> ##[0:3] calib_start_o) else $error("no calibration on resume");
  calib_pulse_a: assert property (
    calib_start_o |=> !calib_start_o)
    else $error("calibration pulse too long");
  calib_cause_a: assert property (
    calib_start_o |-> ctrl_o.power_state_field == PWR_NORMAL &&
    ($past(asleep) || $past(asleep, 2) || $past(asleep, 3)))
    else $error("calibration without resume");
  level_quiet_a: assert property (
    spi_i.cs_n && $past(spi_i.cs_n) |-> $stable(ctrl_o.serial_level_field))
    else $error("level changed while deselected");
  power_quiet_a: assert property (
    spi_i.cs_n && $past(spi_i.cs_n) |-> $stable(ctrl_o.power_state_field))
    else $error("power field changed while deselected");
  quiet_sdo_a: assert property (
    spi_i.cs_n |-> !spi_o.sdo_oe ##1 !spi_o.sdo)
    else $error("sdo active while deselected");
  sdo_stands_a: assert property (
    spi_o.sdo_oe && $changed(spi_o.sdo) |-> !spi_i.sclk)
    else $error("sdo moved while serial clock high");
  // Main scenarios reached
  cover property (calib_start_o);
  cover property (ctrl_o.sleep);
  cover property (spi_o.sdo_oe);
endmodule : scr_regs_properties
bind scr_regs scr_regs_properties chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .spi_i(spi_i), .spi_o(spi_o), .ctrl_o(ctrl_o),
  .calib_start_o(calib_start_o));
`default_nettype wire

/* File: bench/scr_spi_host.sv */
// Serial host model framing commands and data bytes
`timescale 1ns/1ps
`default_nettype none
module scr_spi_host (
  // Clock
  input  wire logic                  clk_i,
  // Serial port pins
  output var  scr_pkg::scr_spi_in_s  spi_o,
  input  wire scr_pkg::scr_spi_out_s spi_i
);
  import scr_pkg::*;
  // Idle: deselected, serial clock parked low
  initial spi_o = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
  // One frame: command then n bytes MSB first, read bits sampled on rise
  task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                      input logic [31:0] wd, output logic [31:0] rq);
    logic [47:0] sh;
    sh = {rd, a, wd};
    rq = '0;
    @(posedge clk_i) #1 spi_o.cs_n = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      spi_o.sdi = sh[47 - i];
      repeat (3) @(posedge clk_i);
      #1 spi_o.sclk = 1'b1;
      // An undriven output reads as the inverse of its last value
      if (i >= 16) rq = {rq[30:0], spi_i.sdo_oe ? spi_i.sdo : ~spi_i.sdo};
      repeat (3) @(posedge clk_i);
      #1 spi_o.sclk = 1'b0;
    end
    repeat (3) @(posedge clk_i);
    #1 spi_o.cs_n = 1'b1;
    spi_o.sdi = ~spi_o.sdi; // Released line shows no stale value
  endtask : xfer
endmodule : scr_spi_host
`default_nettype wire

/* File: bench/scr_regs_tb.sv */
// Self-checking testbench for the serial configuration register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_tb;
  import scr_pkg::*;
  localparam logic [15:0] PID = 16'h6A1D; // Arbitrary value
  localparam logic [15:0] MID = 16'h2C97; // Arbitrary value
  localparam logic [7:0]  REV = 8'h4E;    // Arbitrary value
  localparam logic [3:0]  CLS = 4'h9;     // Arbitrary value
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  scr_spi_in_s  spi_in;
  scr_spi_out_s spi_out;
  scr_ctrl_s    ctrl;
  logic         calib;
  int           mismatches = 0;
  int           checks = 0;
  int           calib_n = 0;
  logic [31:0]  q;
  logic [1:0]   lv [4] = '{LVL_1V8, LVL_1V2, LVL_2V5, LVL_3V3};
  logic [1:0]   pw [6] = '{PWR_SLEEP, PWR_NORMAL, PWR_DOWN, PWR_NORMAL,
                           PWR_RESERVED, PWR_NORMAL};
  scr_regs #(.PART_CLASS_CODE(CLS), .PART_IDENT_CODE(PID),
    .PART_REV_CODE(REV), .MAKER_CODE(MID)) uut (.clk_i(clk_i),
    .rst_i(rst_i), .spi_i(spi_in), .spi_o(spi_out), .ctrl_o(ctrl),
    .calib_start_o(calib));
  scr_spi_host host (.clk_i(clk_i), .spi_o(spi_in), .spi_i(spi_out));
  // Clock and calibration pulse counter
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (calib === 1'b1) calib_n++;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register access through the serial host
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [31:0] r;
    host.xfer(1'b0, a, 1, {d, 24'h0}, r);
  endtask : wr
  task automatic rd(input logic [14:0] a, input int n);
    host.xfer(1'b1, a, n, 32'h0, q);
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // Watchdog: the tests need well under 10000 clock cycles
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  // Test sequence
  initial begin
    logic [1:0] prev;
    int         exp_cal;
    prev = PWR_NORMAL;
    exp_cal = 0;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    foreach (lv[i]) begin
      wr(OFS_SERIAL_LEVEL_CONFIG, {6'h0, lv[i]});
      chk(32'(ctrl.serial_level_field), 32'(lv[i]));
    end
    $display("test levels done");
    rd(OFS_INTERFACE_CONFIG, 4);
    chk(q & 32'hFFFFFF0F, {RST_INTERFACE_CONFIG, 8'h00, 12'h0, CLS});
    rd(OFS_PART_IDENT_LOW, 3);
    chk(q, {8'h00, PID[7:0], PID[15:8], REV});
    wr(OFS_PART_IDENT_LOW, 8'hFF);
    rd(OFS_PART_IDENT_LOW, 1);
    chk(q, {24'h0, PID[7:0]});
    rd(OFS_MAKER_IDENT_LOW, 2);
    chk(q, {16'h0, MID[7:0], MID[15:8]});
    $display("test identity done");
    wr(OFS_INTERFACE_CONFIG, 8'h1C);
    rd(OFS_INTERFACE_CONFIG, 1);
    chk(q, {24'h0, RST_INTERFACE_CONFIG});
    wr(OFS_INTERFACE_CONFIG, 8'h18);
    rd(OFS_INTERFACE_CONFIG, 1);
    chk(q, 32'h00000018);
    rd(OFS_MAKER_IDENT_HIGH, 3);
    chk(q, {8'h00, MID[15:8], MID[7:0], 8'h00});
    $display("test mirror and direction done");
    foreach (pw[i]) begin
      wr(OFS_POWER_STATE_CONFIG, {6'h0, pw[i]});
      chk(32'(ctrl.power_state_field), 32'(pw[i]));
      chk(32'(ctrl.sleep), 32'(pw[i] == PWR_SLEEP));
      chk(32'(ctrl.power_down), 32'(pw[i] == PWR_DOWN));
      if (pw[i] == PWR_NORMAL && prev[1]) exp_cal++;
      chk(calib_n, exp_cal);
      prev = pw[i];
    end
    $display("test power states done");
    wr(OFS_SERIAL_LEVEL_CONFIG, {6'h0, LVL_1V2});
    wr(OFS_POWER_STATE_CONFIG, {6'h0, PWR_RESERVED});
    chk(32'(ctrl.serial_level_field), 32'(LVL_1V2));
    chk(32'(ctrl.power_state_field), 32'(PWR_RESERVED));
    wr(OFS_INTERFACE_CONFIG, 8'hBD);
    chk(32'(ctrl.power_state_field), 32'(PWR_NORMAL));
    chk(32'(ctrl.serial_level_field), 32'(LVL_3V3));
    chk(calib_n, exp_cal);
    rd(OFS_INTERFACE_CONFIG, 1);
    chk(q, {24'h0, RST_INTERFACE_CONFIG});
    $display("test soft reset done");
    print_verdict();
  end
endmodule : scr_regs_tb
`default_nettype wire
